// *** pkg/chgrb_regs.svh ***
`ifndef CHGRB_REGS_SVH
`define CHGRB_REGS_SVH

// ****************************************************************
// Bus address and register locations
// ****************************************************************
// Value is arbitrary
`define CHGRB_I2C_ADDR       7'h5a
`define CHGRB_OFS_STATUS     8'h00
`define CHGRB_OFS_MAIN_CONTROL      8'h01
`define CHGRB_OFS_TIMER_AND_PATH_CONTROL      8'h02
`define CHGRB_OFS_STATEV     8'h03
`define CHGRB_OFS_CHINEV     8'h04

// ****************************************************************
// Field positions
// ****************************************************************
`define CHGRB_STS_SUM        1
`define CHGRB_FLT_SUM        0
`define CHGRB_C1_REG_RST     7
`define CHGRB_C1_CHARGE_ENABLE_BIT      6
`define CHGRB_C1_BST_EN      5
`define CHGRB_C1_FACTORY     4
`define CHGRB_C1_TJ_OPT      3
`define CHGRB_C1_BST_PATH    2
`define CHGRB_C1_TMR_RST     1
`define CHGRB_C1_INT_MASK    0
`define CHGRB_C2_WD_DIS      7
`define CHGRB_C2_CT_DIS      6
`define CHGRB_C2_POWER_PATH_ENABLE    5
`define CHGRB_C2_TRANS       4
`define CHGRB_C2_LIM_SRC     2
`define CHGRB_C2_LIM_EN      1
`define CHGRB_C2_AUTO        0

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define CHGRB_C1_RST         8'h55
`define CHGRB_C2_RST         8'h16
`define CHGRB_C2_WMASK       8'hf7
`define CHGRB_C2_BST_MASK    8'he7
// Low byte status-change events, high byte charger input events
`define CHGRB_EVT_VALID      16'h1a3d
`define CHGRB_EVT_BST_CLR    16'h1a01
`define CHGRB_EVT_DUAL       16'hffff

// ****************************************************************
// Timing
// ****************************************************************
`define CHGRB_CLK_NS         10
`define CHGRB_FLAG_ON_NS     1000
`define CHGRB_FLAG_ON_CYC    ((`CHGRB_FLAG_ON_NS + `CHGRB_CLK_NS - 1) / `CHGRB_CLK_NS)

`endif

// *** pkg/chgrb_pkg.sv ***
package chgrb_pkg;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_RX   = 3'h1,
    I2C_DEC  = 3'h3,
    I2C_ACK  = 3'h2,
    I2C_TX   = 3'h6,
    I2C_MACK = 3'h7
  } chgrb_i2c_state_t;
endpackage

// *** pkg/chgrb_reg_if.sv ***
`timescale 1ns/100ps
interface chgrb_reg_if;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport master (output ptr, output wdata, output wr, output rd, input rdata);
  modport slave  (input ptr, input wdata, input wr, input rd, output rdata);
endinterface

// *** design/chgrb_i2c_slave.sv ***
`timescale 1ns/100ps
`include "chgrb_regs.svh"
module chgrb_i2c_slave (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  output logic        sda_o,
  output logic        sda_drive_n_o,
  chgrb_reg_if.master bus
);
  import chgrb_pkg::*;

  chgrb_i2c_state_t state_r;
  logic [7:0]       shift_r;
  logic [2:0]       bit_cnt_r;
  logic [1:0]       byte_idx_r;
  logic             rw_r;
  logic             scl_q;
  logic             sda_q;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_c;
  logic             stop_c;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;
  assign sda_o    = 1'b0;

  always_ff @(posedge clk_i) begin
    scl_q <= rst_i ? 1'b1 : scl_i;
    sda_q <= rst_i ? 1'b1 : sda_i;
  end

  // Drive changes only on SCL falling, so data never moves while SCL is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r       <= I2C_IDLE;
      shift_r       <= 8'h00;
      bit_cnt_r     <= 3'h0;
      byte_idx_r    <= 2'h0;
      rw_r          <= 1'b0;
      sda_drive_n_o <= 1'b1;
      bus.ptr       <= 8'h00;
      bus.wdata     <= 8'h00;
      bus.wr        <= 1'b0;
      bus.rd        <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (start_c) begin
        state_r       <= I2C_RX;
        bit_cnt_r     <= 3'h0;
        byte_idx_r    <= 2'h0;
        rw_r          <= 1'b0;
        sda_drive_n_o <= 1'b1;
      end else if (stop_c) begin
        state_r       <= I2C_IDLE;
        sda_drive_n_o <= 1'b1;
      end else begin
        case (state_r)
          I2C_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_i};
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                state_r <= I2C_DEC;
              end
            end
          end
          I2C_DEC: begin
            if (scl_fall) begin
              state_r       <= I2C_ACK;
              sda_drive_n_o <= 1'b0;
              if (byte_idx_r == 2'h0) begin
                rw_r <= shift_r[0];
                if (shift_r[7:1] != `CHGRB_I2C_ADDR) begin
                  state_r       <= I2C_IDLE;
                  sda_drive_n_o <= 1'b1;
                end
              end else if (byte_idx_r == 2'h1) begin
                bus.ptr <= shift_r;
              end else begin
                bus.wdata <= shift_r;
                bus.wr    <= 1'b1;
              end
            end
          end
          I2C_ACK: begin
            if (scl_fall) begin
              sda_drive_n_o <= 1'b1;
              bit_cnt_r     <= 3'h0;
              if (byte_idx_r != 2'h2) begin
                byte_idx_r <= byte_idx_r + 2'h1;
              end
              if (rw_r) begin
                shift_r       <= bus.rdata;
                bus.rd        <= 1'b1;
                sda_drive_n_o <= bus.rdata[7];
                state_r       <= I2C_TX;
              end else begin
                state_r <= I2C_RX;
                if (byte_idx_r == 2'h2) begin
                  bus.ptr <= bus.ptr + 8'h01;
                end
              end
            end
          end
          I2C_TX: begin
            if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                sda_drive_n_o <= 1'b1;
                state_r       <= I2C_MACK;
              end else begin
                shift_r       <= {shift_r[6:0], 1'b0};
                sda_drive_n_o <= shift_r[6];
              end
            end
          end
          I2C_MACK: begin
            if (scl_rise) begin
              if (sda_i) begin
                state_r <= I2C_IDLE;
              end else begin
                bus.ptr <= bus.ptr + 8'h01;
                state_r <= I2C_ACK;
              end
            end
          end
          default: begin
            state_r <= I2C_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// *** design/chgrb_top.sv ***
`timescale 1ns/100ps
`include "chgrb_regs.svh"
module chgrb_top (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_drive_n_o,
  input  wire logic       off_state_i,
  input  wire logic       boost_entry_i,
  input  wire logic       charge_entry_i,
  input  wire logic       timer_reset_i,
  input  wire logic       boost_pin_i,
  input  wire logic       tj_high_i,
  input  wire logic       boost_startup_done_i,
  input  wire logic [3:0] limit_pin_i,
  input  wire logic [3:0] limit_reg_i,
  input  wire logic       auto_pin_i,
  input  wire logic [3:0] charge_state_i,
  input  wire logic       batfet_i,
  input  wire logic       timer_events_pending_i,
  input  wire logic       boost_events_pending_i,
  input  wire logic       temp_warn_i,
  input  wire logic       temp_one_i,
  input  wire logic       temp_two_i,
  input  wire logic       temp_sd_i,
  input  wire logic       vbus_ok_i,
  input  wire logic       vin_lo_i,
  input  wire logic       vin_hi_i,
  input  wire logic       batt_ov_i,
  output logic            flag_n_o,
  output logic            charge_enable_o,
  output logic            boost_request_o,
  output logic            factory_mode_o,
  output logic            current_reduce_o,
  output logic            ocp_path_o,
  output logic            rbfet_path_o,
  output logic            timer_restart_o,
  output logic            watchdog_disable_o,
  output logic            charge_timer_disable_o,
  output logic            power_path_enable_o,
  output logic            trans_supply_o,
  output logic [3:0]      limit_value_o,
  output logic            limit_active_o,
  output logic            auto_current_o
);
  import chgrb_pkg::*;

  chgrb_reg_if rif ();

  logic [7:0]  main_control_r;
  logic [7:0]  timer_and_path_control_r;
  logic [15:0] ev_r;
  logic [15:0] src_r;
  logic [15:0] src_now;
  logic [15:0] ev_set;
  logic [15:0] ev_clr;
  logic        boost_pin_q;
  logic        reset_all;
  logic        wr_c1;
  logic        wr_c2;
  logic        rd_stat;
  logic        rd_chin;
  logic        stat_pend;
  logic        fault_pend;
  logic        pend_any;
  logic        new_evt;
  logic [15:0] flag_cnt_r;

  localparam logic [7:0]  C1_RST_V  = `CHGRB_C1_RST;
  localparam logic [15:0] EVT_VALID = `CHGRB_EVT_VALID;
  localparam logic [15:0] EVT_DUAL  = `CHGRB_EVT_DUAL;
  localparam logic [15:0] EVT_BCLR  = `CHGRB_EVT_BST_CLR;

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  chgrb_i2c_slave u_i2c (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .scl_i         (scl_i),
    .sda_i         (sda_i),
    .sda_o         (sda_o),
    .sda_drive_n_o (sda_drive_n_o),
    .bus           (rif.master)
  );

  // ****************************************************************
  // Decode and read path
  // ****************************************************************
  // Register reset takes effect the cycle after the bit is stored
  assign reset_all  = off_state_i | main_control_r[`CHGRB_C1_REG_RST];
  assign wr_c1      = rif.wr && (rif.ptr == `CHGRB_OFS_MAIN_CONTROL);
  assign wr_c2      = rif.wr && (rif.ptr == `CHGRB_OFS_TIMER_AND_PATH_CONTROL);
  assign rd_stat    = rif.rd && (rif.ptr == `CHGRB_OFS_STATEV);
  assign rd_chin    = rif.rd && (rif.ptr == `CHGRB_OFS_CHINEV);
  assign stat_pend  = |ev_r[7:0];
  assign fault_pend = |ev_r[15:8] | timer_events_pending_i | boost_events_pending_i;
  assign pend_any   = stat_pend | fault_pend;

  always_comb begin
    case (rif.ptr)
      `CHGRB_OFS_STATUS: rif.rdata = {charge_state_i, batfet_i, 1'b0, stat_pend, fault_pend};
      `CHGRB_OFS_MAIN_CONTROL:  rif.rdata = main_control_r;
      `CHGRB_OFS_TIMER_AND_PATH_CONTROL:  rif.rdata = timer_and_path_control_r;
      `CHGRB_OFS_STATEV: rif.rdata = ev_r[7:0];
      `CHGRB_OFS_CHINEV: rif.rdata = ev_r[15:8];
      default:           rif.rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Main control register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    boost_pin_q <= rst_i ? 1'b0 : boost_pin_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_all) begin
      main_control_r <= `CHGRB_C1_RST;
    end else begin
      if (wr_c1) begin
        main_control_r <= rif.wdata;
      end else if (timer_reset_i || main_control_r[`CHGRB_C1_TMR_RST]) begin
        main_control_r[`CHGRB_C1_TMR_RST] <= 1'b0;
      end
      if (boost_pin_i && !boost_pin_q) begin
        main_control_r[`CHGRB_C1_BST_EN] <= 1'b1;
      end
      // Mode entry outranks a bus write landing in the same cycle
      if (charge_entry_i) begin
        main_control_r[`CHGRB_C1_BST_EN] <= 1'b0;
      end
      if (boost_entry_i) begin
        main_control_r[`CHGRB_C1_FACTORY] <= C1_RST_V[`CHGRB_C1_FACTORY];
      end
    end
  end

  // ****************************************************************
  // Timer and path control register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_all) begin
      timer_and_path_control_r <= `CHGRB_C2_RST;
    end else if (boost_entry_i) begin
      timer_and_path_control_r <= (timer_and_path_control_r & ~`CHGRB_C2_BST_MASK) | (`CHGRB_C2_RST & `CHGRB_C2_BST_MASK);
    end else if (wr_c2) begin
      timer_and_path_control_r <= rif.wdata & `CHGRB_C2_WMASK;
    end
  end

  // ****************************************************************
  // Event latches
  // ****************************************************************
  assign src_now = {3'b000, vin_lo_i, vin_hi_i, 1'b0, batt_ov_i, 1'b0,
                    2'b00, temp_warn_i, temp_one_i, temp_two_i, temp_sd_i, 1'b0, vbus_ok_i};

  for (genvar i = 0; i < 16; i++) begin : g_evt
    localparam logic VALID = EVT_VALID[i];
    localparam logic DUAL  = EVT_DUAL[i];
    localparam logic BCLR  = EVT_BCLR[i];
    // Reserved positions never set, so they read as zero
    assign ev_set[i] = VALID && (DUAL ? (src_now[i] ^ src_r[i])
                                      : (src_now[i] & ~src_r[i]));
    assign ev_clr[i] = (i < 8 ? rd_stat : rd_chin) | (BCLR & boost_entry_i);
  end

  always_ff @(posedge clk_i) begin
    src_r <= rst_i ? 16'h0000 : src_now;
  end

  // An edge in the read cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_all) begin
      ev_r <= 16'h0000;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | ev_set;
    end
  end

  // ****************************************************************
  // Event flag pulse
  // ****************************************************************
  // Pulse only when everything was clear before, so a burst gives one pulse
  assign new_evt = |ev_set;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_cnt_r <= 16'h0000;
      flag_n_o   <= 1'b1;
    end else if (new_evt && !pend_any && !main_control_r[`CHGRB_C1_INT_MASK] && flag_cnt_r == 16'h0000) begin
      flag_cnt_r <= 16'(`CHGRB_FLAG_ON_CYC);
      flag_n_o   <= 1'b0;
    end else if (flag_cnt_r != 16'h0000) begin
      flag_cnt_r <= flag_cnt_r - 16'h0001;
      flag_n_o   <= (flag_cnt_r == 16'h0001);
    end
  end

  // ****************************************************************
  // Registered control outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_enable_o        <= 1'b1;
      boost_request_o        <= 1'b0;
      factory_mode_o         <= 1'b1;
      current_reduce_o       <= 1'b0;
      ocp_path_o             <= 1'b0;
      rbfet_path_o           <= 1'b0;
      timer_restart_o        <= 1'b0;
      watchdog_disable_o     <= 1'b0;
      charge_timer_disable_o <= 1'b0;
      power_path_enable_o    <= 1'b0;
      trans_supply_o         <= 1'b1;
      limit_value_o          <= 4'h0;
      limit_active_o         <= 1'b1;
      auto_current_o         <= 1'b0;
    end else begin
      charge_enable_o        <= main_control_r[`CHGRB_C1_CHARGE_ENABLE_BIT];
      boost_request_o        <= main_control_r[`CHGRB_C1_BST_EN] & main_control_r[`CHGRB_C1_CHARGE_ENABLE_BIT];
      factory_mode_o         <= main_control_r[`CHGRB_C1_FACTORY];
      current_reduce_o       <= main_control_r[`CHGRB_C1_TJ_OPT] & tj_high_i;
      ocp_path_o             <= boost_startup_done_i & ~main_control_r[`CHGRB_C1_BST_PATH];
      rbfet_path_o           <= boost_startup_done_i & main_control_r[`CHGRB_C1_BST_PATH];
      timer_restart_o        <= wr_c1 & rif.wdata[`CHGRB_C1_TMR_RST];
      watchdog_disable_o     <= timer_and_path_control_r[`CHGRB_C2_WD_DIS];
      charge_timer_disable_o <= timer_and_path_control_r[`CHGRB_C2_CT_DIS];
      power_path_enable_o    <= timer_and_path_control_r[`CHGRB_C2_POWER_PATH_ENABLE];
      trans_supply_o         <= timer_and_path_control_r[`CHGRB_C2_TRANS];
      limit_value_o          <= timer_and_path_control_r[`CHGRB_C2_LIM_SRC] ? limit_pin_i : limit_reg_i;
      limit_active_o         <= timer_and_path_control_r[`CHGRB_C2_LIM_EN];
      auto_current_o         <= timer_and_path_control_r[`CHGRB_C2_LIM_SRC] ? auto_pin_i
                                                           : timer_and_path_control_r[`CHGRB_C2_AUTO];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_reg_rst_write;
    wr_c1 && rif.wdata[`CHGRB_C1_REG_RST];
  endsequence

  sequence s_reg_rst_done;
    main_control_r[`CHGRB_C1_REG_RST] ##1 (main_control_r == `CHGRB_C1_RST && timer_and_path_control_r == `CHGRB_C2_RST
                                    && ev_r == 16'h0000);
  endsequence

  a_soft_reset_all: assert property (s_reg_rst_write |=> s_reg_rst_done)
    else $error("register reset did not restore reset values");

  a_status_summary: assert property (rif.ptr == `CHGRB_OFS_STATUS
      |-> rif.rdata[`CHGRB_STS_SUM] == (ev_r[7:0] != 8'h00))
    else $error("status summary bit wrong");

  a_fault_summary: assert property (rif.ptr == `CHGRB_OFS_STATUS
      && !timer_events_pending_i && !boost_events_pending_i
      |-> rif.rdata[`CHGRB_FLT_SUM] == (ev_r[15:8] != 8'h00))
    else $error("fault summary bit wrong");

  a_boost_pin_set: assert property ($rose(boost_pin_i) && !charge_entry_i
      && !reset_all && !$past(rst_i) |=> main_control_r[`CHGRB_C1_BST_EN])
    else $error("boost pin did not set boost enable");

  a_factory_on_boost: assert property (boost_entry_i && !reset_all
      |=> main_control_r[`CHGRB_C1_FACTORY] && !timer_and_path_control_r[`CHGRB_C2_WD_DIS])
    else $error("boost entry did not restore factory and watchdog bits");

  a_timer_self_clear: assert property (wr_c1 && rif.wdata[`CHGRB_C1_TMR_RST]
      && !reset_all |=> timer_restart_o ##1 (!timer_restart_o || $past(wr_c1)))
    else $error("timer restart not a single pulse");

  a_flag_gated: assert property ($fell(flag_n_o)
      |-> $past(!main_control_r[`CHGRB_C1_INT_MASK]) && $past(!pend_any) && $past(new_evt))
    else $error("flag pulse without a clean unmasked event");

  a_read_clears: assert property (rd_stat && !reset_all && ev_set[7:0] == 8'h00
      |=> ev_r[7:0] == 8'h00)
    else $error("read did not clear status events");

  a_dual_edge_latch: assert property ($changed(temp_sd_i) && !$past(rst_i)
      && !reset_all |=> ev_r[2])
    else $error("dual edge event not latched");

  // Mask keeps the pin idle; events still latch so the host can poll them
  a_mask_blocks_flag: assert property (main_control_r[`CHGRB_C1_INT_MASK]
      && flag_cnt_r == 16'h0000 |=> flag_n_o)
    else $error("flag pulse while interrupts masked");

  a_one_pulse_pending: assert property (pend_any && flag_n_o |=> flag_n_o)
    else $error("second flag pulse while events pending");

  a_charge_clears_boost: assert property (charge_entry_i
      |=> !main_control_r[`CHGRB_C1_BST_EN])
    else $error("charge entry left boost enable set");

  a_boost_timer_and_path_control_reset: assert property (boost_entry_i && !reset_all
      |=> (timer_and_path_control_r & `CHGRB_C2_BST_MASK) == (`CHGRB_C2_RST & `CHGRB_C2_BST_MASK))
    else $error("boost entry did not reset timer and path bits");

  a_off_clears_events: assert property (off_state_i
      |=> ev_r == 16'h0000 && main_control_r == `CHGRB_C1_RST)
    else $error("off state did not clear events and control");

  a_reserved_zero: assert property (rif.ptr == `CHGRB_OFS_CHINEV
      |-> rif.rdata[7:5] == 3'h0 && !rif.rdata[2])
    else $error("reserved event bits not zero");

  a_flag_width: assert property ($rose(flag_n_o) |-> $past(flag_cnt_r) == 16'h0001)
    else $error("flag pulse width wrong");
endmodule

// *** testbench/chgrb_i2c_host.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Bus master model, SCL half period of 8 clocks
// ****************************************************************
module chgrb_i2c_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q;
    repeat (4) @(negedge clk_i);
  endtask
  // Also serves as repeated start, SCL is low on entry
  task automatic start;
    sda_o = 1'b1;
    q;
    scl_o = 1'b1;
    q;
    sda_o = 1'b0;
    q;
    scl_o = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_o = 1'b0;
    q;
    scl_o = 1'b1;
    q;
    sda_o = 1'b1;
    q;
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    q;
    scl_o = 1'b1;
    q;
    r = sda_i;
    q;
    scl_o = 1'b0;
    q;
  endtask
  // Data is released as ones so the device can drive read bits
  task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] r,
                        output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(m, k);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic nak);
    logic [7:0] r;
    logic       k0;
    logic       k1;
    logic       k2;
    start;
    byte_x({a, 1'b0}, 1'b1, r, k0);
    byte_x(p, 1'b1, r, k1);
    byte_x(d, 1'b1, r, k2);
    stop;
    nak = k0 | k1 | k2;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    logic       k;
    start;
    byte_x({a, 1'b0}, 1'b1, r, k);
    byte_x(p, 1'b1, r, k);
    start;
    byte_x({a, 1'b1}, 1'b1, r, k);
    byte_x(8'hff, 1'b1, d, k);
    stop;
  endtask
endmodule

// *** testbench/tb_charger_control_register_bank.sv ***
`timescale 1ns/100ps
`include "chgrb_regs.svh"
module tb_charger_control_register_bank;
  logic clk_i, rst_i, scl, hsda, sda_o, sda_dn, offs, bent, cent, bpin, tj, done, apin, flag_n;
  logic tpend, bpend, ce, br, fm, cr, ocp, rbf, tr, wd, ct, pp, ts, la, ac;
  logic [3:0] lpin, lreg, lval, st;
  logic [15:0] ev, m;
  logic [7:0] d, g;
  logic bf, nak, trst;
  int num_errors, cmp_count, n, tr_cnt, tr_exp;
  wire sda_w = hsda & (sda_dn | sda_o);
  chgrb_i2c_host host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));
  chgrb_top DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_drive_n_o(sda_dn), .off_state_i(offs), .boost_entry_i(bent), .charge_entry_i(cent),
    .timer_reset_i(trst), .boost_pin_i(bpin), .tj_high_i(tj), .boost_startup_done_i(done),
    .limit_pin_i(lpin), .limit_reg_i(lreg), .auto_pin_i(apin), .charge_state_i(st),
    .batfet_i(bf), .timer_events_pending_i(tpend), .boost_events_pending_i(bpend),
    .temp_warn_i(ev[5]), .temp_one_i(ev[4]), .temp_two_i(ev[3]), .temp_sd_i(ev[2]),
    .vbus_ok_i(ev[0]), .vin_lo_i(ev[12]), .vin_hi_i(ev[11]), .batt_ov_i(ev[9]),
    .flag_n_o(flag_n), .charge_enable_o(ce), .boost_request_o(br), .factory_mode_o(fm),
    .current_reduce_o(cr), .ocp_path_o(ocp), .rbfet_path_o(rbf), .timer_restart_o(tr),
    .watchdog_disable_o(wd), .charge_timer_disable_o(ct), .power_path_enable_o(pp),
    .trans_supply_o(ts), .limit_value_o(lval), .limit_active_o(la), .auto_current_o(ac));
  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
    cmp_count++;
    if (v !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wrg(input logic [7:0] p, input logic [7:0] v);
    host.wr(`CHGRB_I2C_ADDR, p, v, nak);
    chk("write ack", 8'h00, {7'h0, nak});
  endtask
  task automatic rg(input logic [7:0] p, input logic [7:0] e);
    host.rd(`CHGRB_I2C_ADDR, p, g);
    chk("register read", e, g);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  function automatic logic [7:0] c2_exp(logic [7:0] v, logic a);
    return {v[7:4], v[1], v[2] ? a : v[0], 2'b00};
  endfunction
  task automatic final_report;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // One count per restart pulse, sampled away from the edge that launches it
  always @(negedge clk_i) begin
    if (tr === 1'b1)
      tr_cnt++;
  end
  // Whole run is near 56k cycles
  initial begin
    #800000;
    num_errors++;
    final_report;
  end
  initial begin
    {rst_i, offs, bent, cent, bpin, tj, done, apin, tpend, bpend} = 10'h200;
    {trst, lpin, lreg, ev} = 25'h0;
    n = $urandom(68);
    {st, bf} = $urandom;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    rg(8'h01, 8'h55);
    rg(8'h02, 8'h16);
    rg(8'h00, {st, bf, 3'b000});
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      {lpin, lreg, apin, tj, done, trst} = $urandom;
      wrg(8'h02, d);
      rg(8'h02, d & 8'hf7);
      chk("timer_and_path_control outputs", c2_exp(d, apin), {wd, ct, pp, ts, la, ac, 2'b00});
      chk("limit", {4'h0, d[2] ? lpin : lreg}, {4'h0, lval});
      d[7] = 1'b0;
      wrg(8'h01, d);
      tr_exp += d[1];
      rg(8'h01, d & 8'hfd);
      chk("main_control outputs", {d[6], d[6] & d[5], d[4], d[3] & tj, done & ~d[2], done & d[2], 2'b0},
          {ce, br, fm, cr, ocp, rbf, 2'b00});
    end
    chk("timer restart pulses", tr_exp[7:0], tr_cnt[7:0]);
    wrg(8'h02, 8'hf7);
    wrg(8'h01, 8'h40);
    pulse(bent);
    rg(8'h02, 8'h16);
    rg(8'h01, 8'h50);
    bpin = 1'b1;
    repeat (4) @(negedge clk_i);
    rg(8'h01, 8'h70);
    pulse(cent);
    rg(8'h01, 8'h50);
    host.wr(`CHGRB_I2C_ADDR ^ 7'h01, 8'h01, 8'h00, nak);
    chk("foreign address", 8'h01, {7'h0, nak});
    wrg(8'h02, 8'h00);
    wrg(8'h01, 8'h80);
    rg(8'h01, 8'h55);
    rg(8'h02, 8'h16);
    wrg(8'h02, 8'h00);
    pulse(offs);
    rg(8'h02, 8'h16);
    for (int k = 1; k < 3; k++) begin
      {tpend, bpend} = k;
      rg(8'h00, {st, bf, 3'b001});
    end
    {tpend, bpend} = 2'b00;
    wrg(8'h01, 8'h54);
    ev[5] = 1'b1;
    for (n = 0; flag_n !== 1'b0 && n < 10; n++) @(negedge clk_i);
    for (n = 0; flag_n === 1'b0 && n < 300; n++) @(negedge clk_i);
    chk("flag length", 8'd100, n[7:0]);
    ev[4] = 1'b1;
    repeat (20) @(negedge clk_i);
    chk("flag held", 8'h01, {7'h0, flag_n});
    rg(8'h00, {st, bf, 3'b010});
    rg(8'h03, 8'h30);
    rg(8'h03, 8'h00);
    rg(8'h00, {st, bf, 3'b000});
    wrg(8'h01, 8'h55);
    for (int j = 0; j < 16; j++) begin
      ev[j] = ~ev[j];
      repeat (4) @(negedge clk_i);
      chk("flag masked", 8'h01, {7'h0, flag_n});
      m = 16'h1a3d & (16'h0001 << j);
      rg(8'h00, {st, bf, 1'b0, |m[7:0], |m[15:8]});
      rg(8'h03, m[7:0]);
      rg(8'h04, m[15:8]);
    end
    final_report;
  end
endmodule
